//--- common/prob_stream_defines.svh
// Offsets, sizes and default values for the probability table tail and difference surface
`ifndef PROB_STREAM_DEFINES_SVH
`define PROB_STREAM_DEFINES_SVH

// Cacheline geometry
`define LINE_BYTES 64
`define LINE_BITS 512

// Probability table tail, byte offsets
`define TBL_FIRST_BYTE 12'd1728
`define TBL_LAST_BYTE 12'd2047
`define YMODE2_OFS 12'd1738
`define YMODE3_OFS 12'd1747
`define YMODE_SET_BYTES 12'd9
`define PART_OFS 12'd1756
`define PART_CTX_BYTES 12'd3
`define PART_LAST_OFS 12'd1801
`define PART_TOTAL_BYTES 12'd48
`define MV0_SIGN_OFS 12'd1807
`define MV0_CLASS_OFS 12'd1808
`define MV_CLASS_BYTES 12'd10
`define MV1_SIGN_OFS 12'd1829
`define MV1_CLASS_OFS 12'd1830
`define MV1_CLASS0_OFS 12'd1840
`define MV1_BITS_OFS 12'd1841
`define MV_BITS_BYTES 12'd10
`define CLASS0_FP_OFS 12'd1851
`define MV_FP0_OFS 12'd1863
`define MV_FP1_OFS 12'd1866
`define CLASS0_HP_OFS 12'd1869
`define MV_HP_OFS 12'd1871
`define HP_BYTES 12'd2
`define PAD_OFS 12'd1873
`define PAD_BYTES 12'd47
`define UV_OFS 12'd1920
`define UV_LAST_OFS 12'd2001
`define UV_SET_BYTES 12'd9
`define SEG_OFS 12'd2010
`define SEG_BYTES 12'd7

// Difference surface
`define DIFF_ENTRIES 12'd1805
`define DIFF_LINES 12'd29
`define DIFF_LAST_BYTE 12'd1855

// Default values
`define SIGN_INTER_DEFAULT 8'h80
`define CLASS0_INTER_DEFAULT 8'hd0
`define SEG_DEFAULT 8'hff
`define YMODE_INTER_DEFAULTS {8'd173, 8'd80, 8'd19, 8'd176, 8'd240, 8'd193, 8'd64, 8'd35, \
	8'd46, 8'd221, 8'd135, 8'd38, 8'd194, 8'd248, 8'd121, 8'd96, 8'd85, 8'd29}
`define PART_KF_DEFAULTS {8'd158, 8'd97, 8'd94, 8'd93, 8'd24, 8'd99, 8'd85, 8'd119, 8'd44, \
	8'd62, 8'd59, 8'd67, 8'd149, 8'd53, 8'd53, 8'd94, 8'd20, 8'd48, 8'd83, 8'd53, 8'd24, \
	8'd52, 8'd18, 8'd18, 8'd150, 8'd40, 8'd39, 8'd78, 8'd12, 8'd26, 8'd67, 8'd33, 8'd11, \
	8'd24, 8'd7, 8'd5, 8'd174, 8'd35, 8'd49, 8'd68, 8'd11, 8'd27, 8'd57, 8'd15, 8'd9, \
	8'd12, 8'd3, 8'd3}
`define PART_INTER_DEFAULTS {8'd199, 8'd122, 8'd141, 8'd147, 8'd63, 8'd159, 8'd148, 8'd133, \
	8'd118, 8'd121, 8'd104, 8'd114, 8'd174, 8'd73, 8'd87, 8'd92, 8'd41, 8'd83, 8'd82, 8'd99, \
	8'd50, 8'd53, 8'd39, 8'd39, 8'd177, 8'd58, 8'd59, 8'd68, 8'd26, 8'd63, 8'd52, 8'd79, \
	8'd25, 8'd17, 8'd14, 8'd12, 8'd222, 8'd34, 8'd30, 8'd72, 8'd16, 8'd44, 8'd58, 8'd32, \
	8'd12, 8'd10, 8'd7, 8'd6}

`endif

//--- common/prob_stream_pkg.sv
// Types shared by the probability surface writer and its bench
package prob_stream_pkg;

	// Kind of a byte position within a surface
	typedef enum logic [1:0] {
		BYTE_SKIP,
		BYTE_PAD,
		BYTE_DATA
	} byte_kind_type;

	// Writer sequencing
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FILL,
		ST_WRITE,
		ST_DONE
	} state_type;

	// One cacheline write toward memory; surface 0 is the table, 1 the difference surface
	typedef struct packed {
		logic surface;
		logic [4:0] line;
		logic [511:0] data;
		logic [63:0] strobe;
	} cl_write_type;

endpackage

//--- hw/prob_surface_writer.sv
// Builds the probability table tail and the difference surface as cacheline writes
//
// Summary of operation
// - Luma mode sets two and three sit as nine bytes at 1738 and 1747.
// - Sixteen three-byte partition contexts packed from 1756 to 1801.
// - Separate keyframe and inter partition defaults; context zero keyframe is 158,97,94.
// - First component sign byte at 1807, inter default 128; ten class bytes at 1808.
// - Second component sign 1829, classes 1830, class-zero 1840, bits 1841.
// - Class-zero fractional groups at 1851..1862; fractional bytes at 1863 and 1866.
// - Class-zero high precision two bytes at 1869, general two bytes at 1871.
// - Forty-seven zero bytes from 1873 pad up to the cacheline boundary.
// - Ten nine-byte chroma mode sets from aligned 1920 through 2001.
// - Seven segment tree bytes at 2010, default 255 each.
// - Keyframe luma mode sets are written all zero.
// - Difference surface holds 1805 eight-bit entries.
// - All 1805 entries are written, filling 29 cachelines of 512 bits.
// - Entries packed gap-free in syntax order, n-th byte is n-th difference.
`timescale 1ns/1ps
`include "prob_stream_defines.svh"

module prob_surface_writer
	import prob_stream_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Command
	input wire logic start,
	input wire logic keyframe,
	input wire logic use_defaults,
	output logic busy,
	output logic done,
	// Probability value stream, one byte per data position of the table in ascending order; pad and skipped positions take none
	input wire logic prob_valid,
	output logic prob_ready,
	input wire logic [7:0] prob_byte,
	// Difference stream, one byte per syntax position in order
	input wire logic diff_valid,
	output logic diff_ready,
	input wire logic [7:0] diff_byte,
	// Cacheline write port
	output logic wr_valid,
	input wire logic wr_ready,
	output cl_write_type wr
);

	state_type state_q;
	logic surface_q;
	logic kf_q;
	logic def_q;
	logic [11:0] ptr_q;
	byte_kind_type kind;
	logic take;
	logic [7:0] value;
	logic line_end;

	// True when offset o lies in [base, base+len)
	function automatic logic in_range(input logic [11:0] o, input logic [11:0] base,
		input logic [11:0] len);
		in_range = (o >= base) && (o < base + len);
	endfunction

	// Classify a table offset: described fields take data, the pad takes zero
	function automatic byte_kind_type table_kind(input logic [11:0] o);
		if (in_range(o, `PAD_OFS, `PAD_BYTES)) begin
			table_kind = BYTE_PAD;
		end else if (in_range(o, `YMODE2_OFS, `PART_OFS + `PART_TOTAL_BYTES - `YMODE2_OFS)) begin
			table_kind = BYTE_DATA;
		end else if (in_range(o, `MV0_SIGN_OFS, 12'd1) || in_range(o, `MV0_CLASS_OFS,
			`MV_CLASS_BYTES)) begin
			table_kind = BYTE_DATA;
		end else if (in_range(o, `MV1_SIGN_OFS, `MV1_BITS_OFS + `MV_BITS_BYTES - `MV1_SIGN_OFS)) begin
			table_kind = BYTE_DATA;
		end else if (in_range(o, `CLASS0_FP_OFS, `MV_HP_OFS + `HP_BYTES - `CLASS0_FP_OFS)) begin
			table_kind = BYTE_DATA;
		end else if (in_range(o, `UV_OFS, `SEG_OFS + `SEG_BYTES - `UV_OFS)) begin
			table_kind = BYTE_DATA;
		end else begin
			table_kind = BYTE_SKIP;
		end
	endfunction

	// Value placed at a table offset, with defaults substituted where known
	function automatic logic [7:0] table_value(input logic [11:0] o, input logic kf,
		input logic dflt, input logic [7:0] in);
		logic [143:0] ymode;
		logic [383:0] part_kf;
		logic [383:0] part_inter;
		logic [11:0] idx;
		ymode = `YMODE_INTER_DEFAULTS;
		part_kf = `PART_KF_DEFAULTS;
		part_inter = `PART_INTER_DEFAULTS;
		idx = 12'd0;
		table_value = in;
		if (in_range(o, `YMODE2_OFS, `YMODE_SET_BYTES + `YMODE_SET_BYTES)) begin
			idx = o - `YMODE2_OFS;
			if (kf) begin
				table_value = 8'h00;
			end else if (dflt) begin
				table_value = ymode[(12'd17 - idx) * 8 +: 8];
			end
		end else if (dflt && in_range(o, `PART_OFS, `PART_TOTAL_BYTES)) begin
			idx = o - `PART_OFS;
			if (kf) begin
				table_value = part_kf[(12'd47 - idx) * 8 +: 8];
			end else begin
				table_value = part_inter[(12'd47 - idx) * 8 +: 8];
			end
		end else if (dflt && (o == `MV0_SIGN_OFS || o == `MV1_SIGN_OFS)) begin
			table_value = kf ? 8'h00 : `SIGN_INTER_DEFAULT;
		end else if (dflt && o == `MV1_CLASS0_OFS) begin
			table_value = kf ? 8'h00 : `CLASS0_INTER_DEFAULT;
		end else if (dflt && in_range(o, `SEG_OFS, `SEG_BYTES)) begin
			table_value = `SEG_DEFAULT;
		end
	endfunction

	// Kind of the current position; difference bytes beyond the last entry pad the line
	always_comb begin
		if (surface_q) begin
			kind = (ptr_q < `DIFF_ENTRIES) ? BYTE_DATA : BYTE_PAD;
		end else begin
			kind = table_kind(ptr_q);
		end
	end

	// Handshake toward both sources
	assign prob_ready = (state_q == ST_FILL) && !surface_q && (kind == BYTE_DATA);
	assign diff_ready = (state_q == ST_FILL) && surface_q && (kind == BYTE_DATA);
	assign take = (state_q == ST_FILL) && ((kind != BYTE_DATA) || (surface_q ? diff_valid :
		prob_valid));
	assign line_end = (ptr_q[5:0] == 6'h3f);
	assign busy = (state_q == ST_FILL) || (state_q == ST_WRITE);

	// Byte to store at the current position
	always_comb begin
		if (kind == BYTE_PAD) begin
			value = 8'h00;
		end else if (surface_q) begin
			value = diff_byte;
		end else begin
			value = table_value(ptr_q, kf_q, def_q, prob_byte);
		end
	end

	// Sequencing and byte pointer
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			surface_q <= 1'b0;
			ptr_q <= 12'h000;
		end else begin
			case (state_q)
				ST_IDLE, ST_DONE: begin
					if (start) begin
						state_q <= ST_FILL;
						surface_q <= 1'b0;
						ptr_q <= `TBL_FIRST_BYTE;
					end else begin
						state_q <= ST_IDLE;
					end
				end
				ST_FILL: begin
					if (take) begin
						if (line_end) begin
							state_q <= ST_WRITE;
						end else begin
							ptr_q <= ptr_q + 12'd1;
						end
					end
				end
				ST_WRITE: begin
					if (wr_ready) begin
						if (!surface_q && ptr_q == `TBL_LAST_BYTE) begin
							state_q <= ST_FILL;
							surface_q <= 1'b1;
							ptr_q <= 12'h000;
						end else if (surface_q && ptr_q == `DIFF_LAST_BYTE) begin
							state_q <= ST_DONE;
						end else begin
							state_q <= ST_FILL;
							ptr_q <= ptr_q + 12'd1;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Frame options latched at start
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			kf_q <= 1'b0;
			def_q <= 1'b0;
		end else if ((state_q == ST_IDLE || state_q == ST_DONE) && start) begin
			kf_q <= keyframe;
			def_q <= use_defaults;
		end
	end

	// Cacheline assembly, lowest offset in the lowest byte lane
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr <= '0;
		end else if ((state_q == ST_IDLE || state_q == ST_DONE) && start) begin
			wr <= '0;
		end else if (state_q == ST_FILL && take) begin
			wr.surface <= surface_q;
			wr.line <= ptr_q[10:6];
			if (kind != BYTE_SKIP) begin
				wr.data[ptr_q[5:0] * 8 +: 8] <= value;
				wr.strobe[ptr_q[5:0]] <= 1'b1;
			end
		end else if (state_q == ST_WRITE && wr_ready) begin
			wr.data <= '0;
			wr.strobe <= '0;
		end
	end

	// Write request and completion pulse
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_valid <= 1'b0;
			done <= 1'b0;
		end else begin
			wr_valid <= (state_q == ST_FILL && take && line_end) ||
				(state_q == ST_WRITE && !wr_ready);
			done <= (state_q == ST_WRITE) && wr_ready && surface_q && (ptr_q == `DIFF_LAST_BYTE);
		end
	end

endmodule

//--- verification/prob_surface_writer_properties.sv
// Port checks on the probability surface writer
`timescale 1ns/1ps
module prob_surface_writer_checker
	import prob_stream_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Completion and write port
	input wire logic done,
	input wire logic wr_valid,
	input wire logic wr_ready,
	input wire cl_write_type wr
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	done_pulse_a: assert property (done |=> !done) else $error("done longer than one cycle");
	done_last_a: assert property (done |-> $past(wr_valid && wr_ready && wr.surface
		&& wr.line == 5'd28)) else $error("done not after last difference line");
	write_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr))
		else $error("write request changed before acceptance");
	line_gap_a: assert property (wr_valid && wr_ready |=> !wr_valid [*8])
		else $error("write request too soon after acceptance");
	diff_full_a: assert property (wr_valid && wr.surface |-> &wr.strobe && wr.line <= 5'd28)
		else $error("difference line not whole");
	table_line_a: assert property (wr_valid && !wr.surface |-> wr.line >= 5'd27)
		else $error("table line out of range");
	pad_zero_a: assert property (wr_valid && !wr.surface && wr.line == 5'd29
		|-> wr.data[511:136] == '0 && &wr.strobe[63:17]) else $error("padding not zero");
	seg_end_a: assert property (wr_valid && !wr.surface && wr.line == 5'd31
		|-> wr.strobe[63:33] == '0 && &wr.strobe[32:26]) else $error("segment bytes wrong");
endmodule

bind prob_surface_writer prob_surface_writer_checker u_prob_surface_writer_checker (
	.clock(clock), .rst_n(rst_n), .done(done),
	.wr_valid(wr_valid), .wr_ready(wr_ready), .wr(wr));

//--- verification/prob_memory_model.sv
// Memory holding the probability table tail and the difference surface
`timescale 1ns/1ps
module prob_memory_model
	import prob_stream_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Pacing, high accepts one write slot in four
	input wire logic slow,
	// Cacheline write port
	input wire logic wr_valid,
	output logic wr_ready,
	input wire cl_write_type wr
);
	logic [7:0] tbl [0:2047];
	logic [7:0] dif [0:1855];
	logic [1:0] pace_q;
	int n_wr;

	// Strobed bytes land by byte address, lowest lane at the lowest address
	always @(posedge clock) begin
		pace_q <= rst_n ? pace_q + 2'h1 : 2'h0;
		wr_ready <= rst_n && (!slow || pace_q == 2'h2);
		if (wr_valid && wr_ready) begin
			n_wr <= n_wr + 1;
			for (int k = 0; k < 64; k++) begin
				if (wr.strobe[k] && wr.surface) dif[wr.line * 64 + k] <= wr.data[8 * k +: 8];
				if (wr.strobe[k] && !wr.surface) tbl[wr.line * 64 + k] <= wr.data[8 * k +: 8];
			end
		end
	end
	// Table offsets are absolute
endmodule

//--- verification/prob_surface_writer_tb_top.sv
// Bench for the probability surface writer
`timescale 1ns/1ps
`include "prob_stream_defines.svh"
module prob_surface_writer_tb_top
	import prob_stream_pkg::*;
;
	logic clock = 0, rst_n = 0, start = 0, keyframe = 0, use_defaults = 0, slow = 0;
	logic prob_valid = 0, diff_valid = 0, busy, done, prob_ready, diff_ready, wr_valid, wr_ready;
	logic [7:0] prob_byte = 8'h00, diff_byte = 8'h00;
	cl_write_type wr;
	int n_fail = 0, check_count = 0, pn = 0, dn = 0, cyc = 0;
	logic dtk = 0;
	logic [143:0] ym = `YMODE_INTER_DEFAULTS;
	logic [383:0] pk = `PART_KF_DEFAULTS;
	logic [383:0] pi = `PART_INTER_DEFAULTS;

	prob_surface_writer u_prob_surface_writer (.clock(clock), .rst_n(rst_n), .start(start),
		.keyframe(keyframe), .use_defaults(use_defaults), .busy(busy), .done(done),
		.prob_valid(prob_valid), .prob_ready(prob_ready), .prob_byte(prob_byte),
		.diff_valid(diff_valid), .diff_ready(diff_ready), .diff_byte(diff_byte),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr(wr));
	prob_memory_model u_prob_memory_model (.clock(clock), .rst_n(rst_n), .slow(slow),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr(wr));

	always #5 clock = ~clock;

	// Count takes and cycles; cut a hang short
	always @(posedge clock) begin
		cyc <= cyc + 1;
		pn <= pn + (prob_valid && prob_ready);
		dn <= dn + (diff_valid && diff_ready);
		dtk <= diff_valid && diff_ready; // Offered byte was taken at this edge
		if (cyc == 40000) begin
			n_fail++;
			wrap_up();
		end
	end

	// Stream sources; difference source pauses but never drops an offered byte
	always @(negedge clock) begin
		prob_byte <= pn[7:0] + 8'h11;
		diff_byte <= dn[7:0] ^ 8'h5a;
		prob_valid <= busy && pn < 218;
		diff_valid <= (diff_valid && !dtk) || (busy && dn < 1805 && cyc[2:0] != 3'h3);
	end

	task automatic chk(logic [7:0] seen, logic [7:0] want);
		check_count++;
		if (seen !== want) begin
			n_fail++;
			$display("wrong value at %0t: got %h want %h", $time, seen, want);
		end
	endtask

	// One run, optionally with a refused restart, then both surfaces compared
	task automatic run(logic kf, logic df, logic sl, logic again);
		logic [7:0] e;
		int n;
		u_prob_memory_model.tbl = '{default: 8'haa};
		u_prob_memory_model.dif = '{default: 8'haa};
		u_prob_memory_model.n_wr = 0;
		pn = 0;
		dn = 0;
		slow = sl;
		keyframe = kf;
		use_defaults = df;
		start = 1;
		@(negedge clock) start = 0;
		keyframe = !kf;
		chk(8'(busy), 8'h01);
		repeat (100) @(negedge clock);
		start = again;
		@(negedge clock) start = 0;
		while (!done) @(negedge clock);
		chk(8'(busy), 8'h00);
		chk(8'(u_prob_memory_model.n_wr), 8'd34);
		n = 0;
		for (int a = 1728; a < 2048; a++) begin
			e = 8'haa;
			if ((a >= 1738 && a < 1804) || (a >= 1807 && a < 1818) || (a >= 1829 && a < 1873)
				|| (a >= 1920 && a < 2017)) begin
				e = n[7:0] + 8'h11;
				n++;
			end
			if (a >= 1873 && a < 1920) e = 8'h00;
			if (a >= 1738 && a < 1756 && (kf || df)) e = kf ? 8'h00 : ym[8 * (1755 - a) +: 8];
			if (df && a >= 1756 && a < 1804) e = kf ? pk[8 * (1803 - a) +: 8] : pi[8 * (1803 - a) +: 8];
			if (df && (a == 1807 || a == 1829)) e = kf ? 8'h00 : 8'h80;
			if (df && a == 1840) e = kf ? 8'h00 : 8'hd0;
			if (df && a >= 2010 && a < 2017) e = 8'hff;
			chk(u_prob_memory_model.tbl[a], e);
		end
		for (int i = 0; i < 1856; i++) begin
			e = i < 1805 ? i[7:0] ^ 8'h5a : 8'h00;
			chk(u_prob_memory_model.dif[i], e);
		end
	endtask

	// Inter frame from the stream, slow memory, restart while busy ignored
	task automatic scen_stream();
		run(1'b0, 1'b0, 1'b1, 1'b1);
	endtask

	// Keyframe defaults, fast memory, no restart
	task automatic scen_key();
		run(1'b1, 1'b1, 1'b0, 1'b0);
	endtask

	// Inter frame defaults
	task automatic scen_inter();
		run(1'b0, 1'b1, 1'b0, 1'b0);
	endtask

	// Keyframe without defaults, slow memory: luma sets zero, the rest from the stream
	task automatic scen_key_stream();
		run(1'b1, 1'b0, 1'b1, 1'b0);
	endtask

	task automatic wrap_up();
		if (n_fail == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(negedge clock);
		rst_n = 1;
		scen_stream();
		scen_key();
		scen_inter();
		scen_key_stream();
		wrap_up();
	end
endmodule
